// ### hw/slk_pkg.sv
// slk_pkg: constants and types shared by the serial link control block
// assumes nothing beyond a SystemVerilog compiler
package slk_pkg;

  // ----------------------------------------
  // operating mode selector codes
  // ----------------------------------------
  localparam logic [3:0] SLK_SEL_5 = 4'h5;
  localparam logic [3:0] SLK_SEL_6 = 4'h6;
  localparam logic [3:0] SLK_SEL_8 = 4'h8;
  localparam logic [3:0] SLK_SEL_A = 4'hA;
  localparam logic [3:0] SLK_SEL_B = 4'hB;
  localparam logic [3:0] SLK_SEL_D = 4'hD;
  localparam logic [3:0] SLK_SEL_RST = 4'h5;

  // ----------------------------------------
  // station limits and protocol codes
  // ----------------------------------------
  localparam int unsigned SLK_MAX_STATIONS = 32;
  localparam logic [1:0] SLK_PROTO_DED = 2'h0;
  localparam logic [1:0] SLK_PROTO_NOP = 2'h1;
  localparam logic [1:0] SLK_PROTO_BID = 2'h2;

  // ----------------------------------------
  // indicator timing
  // ----------------------------------------
  localparam int unsigned SLK_CLK_HZ = 10_000_000;
  localparam int unsigned SLK_BLINK_MS = 50;
  localparam int unsigned SLK_BLINK_CYC = SLK_CLK_HZ / 1000 * SLK_BLINK_MS;

  // ----------------------------------------
  // transfer sequencer states
  // ----------------------------------------
  typedef enum logic [3:0] {
    SLK_IDLE = 4'h1,
    SLK_RECV = 4'h2,
    SLK_SEND = 4'h4,
    SLK_DONE = 4'h8
  } slk_state_e;

endpackage

// ### hw/slk_blink.sv
// slk_blink: activity indicator that toggles while its activity level stands
// assumes activity is synchronous to core_clk
`timescale 1ns/1ns
module slk_blink
  import slk_pkg::*;
#(
  parameter int unsigned HALF_CYC = SLK_BLINK_CYC
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // activity in, lamp out
  input  wire logic active,
  output logic      lamp
);

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        lamp_reg;
  logic        lamp_next;

  always_comb begin
    cnt_next  = cnt_reg;
    lamp_next = lamp_reg;
    if (!active) begin
      cnt_next  = 32'h0;
      lamp_next = 1'b0;
    end else if (cnt_reg >= HALF_CYC - 1) begin
      cnt_next  = 32'h0;
      lamp_next = ~lamp_reg;
    end else begin
      cnt_next = cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_reg  <= 32'h0;
      lamp_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      lamp_reg <= lamp_next;
    end
  end

  assign lamp = lamp_reg;

endmodule

// ### hw/slk_ctrl.sv
// slk_ctrl: serial link mode, handshake and transmit gating control
// assumes pins enter unsynchronised; host-side strobes are core_clk pulses
`timescale 1ns/1ns

// Notes on behaviour
// - multi-drop line holds at most 32 stations, hosts and modules together
// - in multi-drop, only host-command dedicated-protocol exchanges are served
// - full multi-drop needs RS-422 and selector 5, 6 or 8
// - selector A, B or D: dedicated protocol only with the main channel host
// - normal mode switch during an exchange waits for its end
// - forced mode switch ends the running exchange at once
// - with no exchange running, any mode switch applies at once
// - full duplex with carrier check: transmit only while carrier present
// - full duplex with carrier check: carrier loss mid dedicated exchange resets the transfer sequence
// - full duplex, carrier check off: transmit regardless of carrier (half duplex with check off is a config error)
// - receive lamp blinks while characters arrive
// - send lamp blinks while characters go out
// - dedicated or bidirectional mode: DTR on once communication enabled
// - no-protocol with DTR/DSR control and communication enabled: DTR follows receive buffer space, otherwise DTR on
// - with DTR/DSR control and no RS-422 wiring, no transmit while DSR off
// - no transmit while clear-to-send off
// - full duplex: request-to-send follows module ready flag
// - half duplex: never start transmitting while carrier present
module slk_ctrl
  import slk_pkg::*;
#(
  parameter int unsigned BLINK_CYC = SLK_BLINK_CYC,
  parameter int unsigned FREE_W    = 8,
  parameter logic [FREE_W-1:0] FREE_LOW = 8'h04
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // configuration
  input  wire logic [3:0]        sel_code,
  input  wire logic [1:0]        proto_mode,
  input  wire logic              multi_drop,
  input  wire logic              main_channel,
  input  wire logic              rs422_wiring,
  input  wire logic              half_duplex,
  input  wire logic              cd_check_en,
  input  wire logic              dtr_dsr_en,
  input  wire logic              comm_enable,
  input  wire logic              module_ready_flag,
  input  wire logic [5:0]        station_count,
  // mode switch requests
  input  wire logic              mode_req,
  input  wire logic              mode_force,
  input  wire logic [1:0]        mode_new,
  // exchange requests from the character engine
  input  wire logic              host_cmd,
  input  wire logic              unsolicited_req,
  input  wire logic              tx_char_busy,
  input  wire logic              rx_char_busy,
  input  wire logic              xfer_end,
  input  wire logic [FREE_W-1:0] rx_free,
  // serial pins
  input  wire logic              carrier_detect_in,
  input  wire logic              clear_to_send_in,
  input  wire logic              dsr_in,
  input  wire logic              receive_line,
  // outputs
  output logic                   request_to_send_out,
  output logic                   dtr_out,
  output logic                   tx_allow,
  output logic                   cfg_error,
  output logic                   xfer_abort,
  output logic [1:0]             active_mode,
  output logic                   busy,
  output logic                   send_lamp,
  output logic                   recv_lamp
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic       cd_s;
  logic       cts_s;
  logic       dsr_s;
  logic       rxd_d_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
      rxd_d_reg <= 1'b1;
    end else begin
      sync1_reg <= {receive_line, dsr_in, clear_to_send_in, carrier_detect_in};
      sync2_reg <= sync1_reg;
      rxd_d_reg <= sync2_reg[3];
    end
  end

  assign cd_s  = sync2_reg[0];
  assign cts_s = sync2_reg[1];
  assign dsr_s = sync2_reg[2];

  // ----------------------------------------
  // configuration checks
  // ----------------------------------------
  logic sel_full_mn;
  logic sel_main_only;
  logic cfg_bad;
  logic cmd_ok;
  logic [1:0] active_reg;
  logic [1:0] active_next;

  assign sel_full_mn   = (sel_code == SLK_SEL_5) || (sel_code == SLK_SEL_6) ||
                         (sel_code == SLK_SEL_8);
  assign sel_main_only = (sel_code == SLK_SEL_A) || (sel_code == SLK_SEL_B) ||
                         (sel_code == SLK_SEL_D);
  assign cfg_bad = (half_duplex && !cd_check_en) ||
                   (multi_drop && (station_count > 6'(SLK_MAX_STATIONS))) ||
                   (multi_drop && !(rs422_wiring && sel_full_mn) &&
                    !sel_main_only);

  // which requests may open an exchange
  always_comb begin
    cmd_ok = 1'b0;
    if (!cfg_bad && comm_enable) begin
      if (multi_drop) begin
        cmd_ok = host_cmd && (active_reg == SLK_PROTO_DED);
      end else begin
        cmd_ok = host_cmd || (unsolicited_req && (active_reg != SLK_PROTO_DED));
      end
      if (sel_main_only && (active_reg == SLK_PROTO_DED) && !main_channel) begin
        cmd_ok = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // exchange sequencer and mode switching
  // ----------------------------------------
  slk_state_e  st_reg;
  slk_state_e  st_next;
  logic [1:0]  pend_mode_reg;
  logic [1:0]  pend_mode_next;
  logic        pend_reg;
  logic        pend_next;
  logic        abort_reg;
  logic        abort_next;
  logic        busy_reg;
  logic        busy_next;
  logic        cd_lost;

  assign cd_lost = !half_duplex && cd_check_en && !cd_s &&
                   (active_reg == SLK_PROTO_DED) && busy_reg;

  always_comb begin
    st_next        = st_reg;
    active_next    = active_reg;
    pend_mode_next = pend_mode_reg;
    pend_next      = pend_reg;
    abort_next     = 1'b0;
    case (st_reg)
      SLK_IDLE: begin
        if (cmd_ok) begin
          st_next = SLK_RECV;
        end
      end
      SLK_RECV: begin
        if (!rx_char_busy) begin
          st_next = SLK_SEND;
        end
      end
      SLK_SEND: begin
        if (xfer_end) begin
          st_next = SLK_DONE;
        end
      end
      SLK_DONE: begin
        st_next = SLK_IDLE;
      end
      default: begin
        st_next = SLK_IDLE;
      end
    endcase
    if (cd_lost) begin
      st_next    = SLK_IDLE;
      abort_next = 1'b1;
    end
    if (mode_req) begin
      if (!busy_reg) begin
        active_next = mode_new;
        pend_next   = 1'b0;
      end else if (mode_force) begin
        active_next = mode_new;
        pend_next   = 1'b0;
        st_next     = SLK_IDLE;
        abort_next  = 1'b1;
      end else begin
        pend_mode_next = mode_new;
        pend_next      = 1'b1;
      end
    end else if (pend_reg && (st_reg == SLK_DONE || st_next == SLK_IDLE)) begin
      active_next = pend_mode_reg;
      pend_next   = 1'b0;
    end
    busy_next = (st_next != SLK_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg        <= SLK_IDLE;
      active_reg    <= SLK_PROTO_DED;
      pend_mode_reg <= SLK_PROTO_DED;
      pend_reg      <= 1'b0;
      abort_reg     <= 1'b0;
      busy_reg      <= 1'b0;
    end else begin
      st_reg        <= st_next;
      active_reg    <= active_next;
      pend_mode_reg <= pend_mode_next;
      pend_reg      <= pend_next;
      abort_reg     <= abort_next;
      busy_reg      <= busy_next;
    end
  end

  // ----------------------------------------
  // handshake outputs
  // ----------------------------------------
  logic tx_ok;
  logic tx_reg;
  logic rts_reg;
  logic rts_next;
  logic dtr_reg;
  logic dtr_next;
  logic err_reg;

  always_comb begin
    tx_ok = !cfg_bad && cts_s;
    if (dtr_dsr_en && !rs422_wiring && !dsr_s) begin
      tx_ok = 1'b0;
    end
    if (!half_duplex && cd_check_en && !cd_s) begin
      tx_ok = 1'b0;
    end
    if (half_duplex && cd_s && !tx_char_busy) begin
      tx_ok = 1'b0;
    end
  end

  always_comb begin
    if (half_duplex) begin
      rts_next = tx_char_busy;
    end else begin
      rts_next = module_ready_flag;
    end
    dtr_next = 1'b1;
    if (comm_enable && dtr_dsr_en && (active_reg == SLK_PROTO_NOP)) begin
      dtr_next = (rx_free > FREE_LOW);
    end else if (active_reg != SLK_PROTO_NOP) begin
      dtr_next = comm_enable || !dtr_dsr_en;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_reg  <= 1'b0;
      rts_reg <= 1'b0;
      dtr_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      tx_reg  <= tx_ok;
      rts_reg <= rts_next;
      dtr_reg <= dtr_next;
      err_reg <= cfg_bad;
    end
  end

  assign tx_allow            = tx_reg;
  assign request_to_send_out = rts_reg;
  assign dtr_out             = dtr_reg;
  assign cfg_error           = err_reg;
  assign xfer_abort          = abort_reg;
  assign active_mode         = active_reg;
  assign busy                = busy_reg;

  // ----------------------------------------
  // activity lamps
  // ----------------------------------------
  logic rx_act;

  assign rx_act = rx_char_busy || (sync2_reg[3] != rxd_d_reg);

  slk_blink #(.HALF_CYC(BLINK_CYC)) u_recv_lamp (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .active   (rx_act),
    .lamp     (recv_lamp)
  );

  slk_blink #(.HALF_CYC(BLINK_CYC)) u_send_lamp (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .active   (tx_char_busy),
    .lamp     (send_lamp)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_force_mid;
    mode_req && mode_force && busy_reg;
  endsequence

  a_force_ends: assert property (s_force_mid |=> (st_reg == SLK_IDLE) && xfer_abort)
    else $error("forced switch did not end exchange");
  a_norm_defer: assert property (mode_req && !mode_force && busy_reg && !cd_lost
    |=> pend_reg && (active_reg == $past(active_reg)))
    else $error("normal switch not deferred");
  a_idle_apply: assert property (mode_req && !busy_reg |=> active_reg == $past(mode_new))
    else $error("idle switch not applied");
  a_cd_gate: assert property (!half_duplex && cd_check_en && !cd_s |=> !tx_allow)
    else $error("sent without carrier");
  a_cd_reset: assert property (cd_lost |=> st_reg == SLK_IDLE)
    else $error("carrier loss kept sequence");
  a_cts_gate: assert property (!cts_s |=> !tx_allow)
    else $error("sent without clear to send");
  a_dsr_gate: assert property (dtr_dsr_en && !rs422_wiring && !dsr_s |=> !tx_allow)
    else $error("sent without data set ready");
  a_rts_ready: assert property (!half_duplex |=> request_to_send_out == $past(module_ready_flag))
    else $error("request to send not following ready");
  a_bad_cfg: assert property (half_duplex && !cd_check_en |=> cfg_error && !tx_allow)
    else $error("illegal duplex setting accepted");
  a_mn_unsol: assert property (multi_drop && !host_cmd && !busy_reg |=> !busy_reg)
    else $error("multi-drop exchange without host command");
  a_hd_start: assert property (half_duplex && cd_s && !tx_char_busy |=> !tx_allow)
    else $error("half duplex start with carrier");

endmodule

// ### bench/slk_host_model.sv
// slk_host_model: far-side computer driving the serial status pins
// assumes pins are high for ON and the bench sets wishes by non-blocking writes
`timescale 1ns/1ns
module slk_host_model (
  // clock
  input  wire logic core_clk,
  // wanted pin states
  input  wire logic cd_on,
  input  wire logic cts_on,
  input  wire logic dsr_on,
  input  wire logic line_act,
  // pins toward the block
  output logic      carrier_detect_in,
  output logic      clear_to_send_in,
  output logic      dsr_in,
  output logic      receive_line
);
  // pins move only at the falling edge
  always @(negedge core_clk) begin
    carrier_detect_in <= cd_on;
    clear_to_send_in  <= cts_on;
    dsr_in            <= dsr_on;
    receive_line      <= line_act ? ~receive_line : 1'b1;
  end
endmodule

// ### bench/slk_ctrl_tb.sv
// slk_ctrl_tb: self-checking bench for the serial link control block
// assumes slk_pkg, slk_blink, slk_ctrl and slk_host_model are compiled first
`timescale 1ns/1ns
module slk_ctrl_tb;
  import slk_pkg::*;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic       core_clk = 1'b0, rst_n = 1'b0;
  logic [3:0] sel_code = SLK_SEL_5;
  logic [1:0] proto_mode = SLK_PROTO_DED, mode_new = 2'h0, active_mode;
  logic       multi_drop = 1'b0, main_channel = 1'b1, rs422_wiring = 1'b0;
  logic       half_duplex = 1'b0, cd_check_en = 1'b1, dtr_dsr_en = 1'b0;
  logic       comm_enable = 1'b1, module_ready_flag = 1'b1;
  logic [5:0] station_count = 6'h02;
  logic       mode_req = 1'b0, mode_force = 1'b0, host_cmd = 1'b0;
  logic       unsolicited_req = 1'b0, tx_char_busy = 1'b0, rx_char_busy = 1'b0;
  logic       xfer_end = 1'b0;
  logic [7:0] rx_free = 8'h10;
  logic       cd_on = 1'b1, cts_on = 1'b1, dsr_on = 1'b1, line_act = 1'b0;
  logic       carrier_detect_in, clear_to_send_in, dsr_in, receive_line;
  logic       request_to_send_out, dtr_out, tx_allow, cfg_error, xfer_abort;
  logic       busy, send_lamp, recv_lamp;
  int         miscompares = 0, n_tests = 0, cycles = 0;

  always #50 core_clk = ~core_clk;

  slk_host_model host (.core_clk(core_clk), .cd_on(cd_on), .cts_on(cts_on),
    .dsr_on(dsr_on), .line_act(line_act), .carrier_detect_in(carrier_detect_in),
    .clear_to_send_in(clear_to_send_in), .dsr_in(dsr_in), .receive_line(receive_line));

  slk_ctrl #(.BLINK_CYC(4)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .sel_code(sel_code), .proto_mode(proto_mode), .multi_drop(multi_drop),
    .main_channel(main_channel), .rs422_wiring(rs422_wiring),
    .half_duplex(half_duplex), .cd_check_en(cd_check_en), .dtr_dsr_en(dtr_dsr_en),
    .comm_enable(comm_enable), .module_ready_flag(module_ready_flag),
    .station_count(station_count), .mode_req(mode_req), .mode_force(mode_force),
    .mode_new(mode_new), .host_cmd(host_cmd), .unsolicited_req(unsolicited_req),
    .tx_char_busy(tx_char_busy), .rx_char_busy(rx_char_busy), .xfer_end(xfer_end),
    .rx_free(rx_free), .carrier_detect_in(carrier_detect_in),
    .clear_to_send_in(clear_to_send_in), .dsr_in(dsr_in),
    .receive_line(receive_line), .request_to_send_out(request_to_send_out),
    .dtr_out(dtr_out), .tx_allow(tx_allow), .cfg_error(cfg_error),
    .xfer_abort(xfer_abort), .active_mode(active_mode), .busy(busy),
    .send_lamp(send_lamp), .recv_lamp(recv_lamp));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic finish_test();
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic cmd();
    host_cmd <= 1'b1;  // only offered while idle
    cyc(1);
    host_cmd <= 1'b0;
    cyc(2);
  endtask

  task automatic done();
    xfer_end <= 1'b1;
    cyc(1);
    xfer_end <= 1'b0;
    cyc(3);
  endtask

  task automatic mode_sw(input logic [1:0] m, input logic f);
    mode_new   <= m;
    mode_force <= f;
    mode_req   <= 1'b1;
    cyc(1);
    mode_req   <= 1'b0;
    cyc(3);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_gate();
    logic [6:0] tbl [8];
    tbl = '{7'b0111101, 7'b0101100, 7'b0001101, 7'b0010100,
            7'b0011010, 7'b0011001, 7'b1111100, 7'b1001100};
    foreach (tbl[i]) begin
      {half_duplex, cd_check_en, cd_on, cts_on, dsr_on, dtr_dsr_en} <= tbl[i][6:1];
      cyc(6);
      chk("tx_allow", 8'(tx_allow), 8'(tbl[i][0]));
      chk("cfg_error", 8'(cfg_error), 8'(tbl[i][6] & ~tbl[i][5]));
    end
    {half_duplex, cd_check_en, cd_on, cts_on, dsr_on, dtr_dsr_en} <= 6'b011110;
    cyc(6);
  endtask

  task automatic t_rts_dtr();
    module_ready_flag <= 1'b0;
    comm_enable <= 1'b0;
    dtr_dsr_en <= 1'b1;
    cyc(3);
    chk("rts", 8'(request_to_send_out), 8'h00);
    chk("dtr", 8'(dtr_out), 8'h00);
    module_ready_flag <= 1'b1;
    comm_enable <= 1'b1;
    cyc(3);
    chk("rts", 8'(request_to_send_out), 8'h01);
    chk("dtr", 8'(dtr_out), 8'h01);
    mode_sw(SLK_PROTO_NOP, 1'b0);
    chk("mode", 8'(active_mode), 8'(SLK_PROTO_NOP));
    dtr_dsr_en <= 1'b1;
    rx_free <= 8'h05;
    cyc(3);
    chk("dtr", 8'(dtr_out), 8'h01);
    rx_free <= 8'h04;
    cyc(3);
    chk("dtr", 8'(dtr_out), 8'h00);
    dtr_dsr_en <= 1'b0;
    rx_free <= 8'h10;
    mode_sw(SLK_PROTO_DED, 1'b1);
    chk("mode", 8'(active_mode), 8'(SLK_PROTO_DED));
  endtask

  task automatic t_switch();
    logic ab;
    cmd();
    chk("busy", 8'(busy), 8'h01);
    mode_sw(SLK_PROTO_BID, 1'b0);
    chk("mode", 8'(active_mode), 8'(SLK_PROTO_DED));
    done();
    chk("mode", 8'(active_mode), 8'(SLK_PROTO_BID));
    chk("busy", 8'(busy), 8'h00);
    cmd();
    mode_sw(SLK_PROTO_DED, 1'b1);
    chk("mode", 8'(active_mode), 8'(SLK_PROTO_DED));
    chk("busy", 8'(busy), 8'h00);
    cmd();
    ab = 1'b0;
    cd_on <= 1'b0;
    repeat (8) begin
      cyc(1);
      ab |= xfer_abort;
    end
    chk("abort", 8'(ab), 8'h01);
    chk("busy", 8'(busy), 8'h00);
    cd_on <= 1'b1;
    cyc(5);
  endtask

  task automatic t_multi();
    multi_drop <= 1'b1;
    rs422_wiring <= 1'b1;
    sel_code <= SLK_SEL_A;
    main_channel <= 1'b0;
    cyc(4);
    cmd();
    chk("busy", 8'(busy), 8'h00);
    main_channel <= 1'b1;
    cmd();
    chk("busy", 8'(busy), 8'h01);
    done();
    sel_code <= SLK_SEL_6;
    main_channel <= 1'b0;
    cyc(2);
    cmd();
    chk("busy", 8'(busy), 8'h01);
    done();
    mode_sw(SLK_PROTO_NOP, 1'b0);
    {unsolicited_req, host_cmd} <= 2'b11;
    cyc(1);
    {unsolicited_req, host_cmd} <= 2'b00;
    cyc(2);
    chk("busy", 8'(busy), 8'h00);
    mode_sw(SLK_PROTO_DED, 1'b0);
    station_count <= 6'h21;
    cyc(3);
    chk("cfg_error", 8'(cfg_error), 8'h01);
    station_count <= 6'h20;
    cyc(3);
    chk("cfg_error", 8'(cfg_error), 8'h00);
    {multi_drop, rs422_wiring, main_channel, sel_code} <= {3'b001, SLK_SEL_5};
    station_count <= 6'h02;
    cyc(3);
  endtask

  initial begin
    cyc(5);
    chk("outs", {busy, tx_allow, cfg_error, xfer_abort, request_to_send_out, dtr_out,
                 active_mode}, 8'h00);
    rst_n <= 1'b1;
    cyc(6);
    t_gate();
    t_rts_dtr();
    t_switch();
    t_multi();
    t_lamps();
    finish_test();
  end

  // ----------------------------------------
  // lamp activity
  // ----------------------------------------
  task automatic t_lamps();
    int ns, nr;
    logic ps, pr;
    ns = 0;
    nr = 0;
    tx_char_busy <= 1'b1;
    rx_char_busy <= 1'b1;
    line_act <= 1'b1;
    cyc(3);
    ps = send_lamp;
    pr = recv_lamp;
    repeat (20) begin
      cyc(1);
      ns += int'(send_lamp !== ps);
      nr += int'(recv_lamp !== pr);
      ps = send_lamp;
      pr = recv_lamp;
    end
    chk("send_blink", 8'(ns >= 2), 8'h01);
    chk("recv_blink", 8'(nr >= 2), 8'h01);
    {tx_char_busy, rx_char_busy, line_act} <= 3'b000;
    cyc(12);
    chk("lamps_off", {6'h00, send_lamp, recv_lamp}, 8'h00);
  endtask
endmodule
